// [hw/aaexe_pkg.sv]
/*
 * Shared constants and types of the add and bit-operation execute unit:
 * APB register offsets, command field layout, operation codes, flags.
 * Assumes a 32-bit APB master and a single 200 MHz clock domain.
 */
package aaexe_pkg;

    // =====================================================================
    // Widths
    // =====================================================================
    localparam int AAEXE_DW = 8;
    localparam int AAEXE_AW = 7;
    localparam int AAEXE_BW = 3;
    localparam int AAEXE_OPW = 3;
    localparam int AAEXE_DEPTH = 128;

    // =====================================================================
    // Register byte offsets
    // =====================================================================
    localparam logic [11:0] AAEXE_OFS_ACC = 12'h000;
    localparam logic [11:0] AAEXE_OFS_FLAGS = 12'h004;
    localparam logic [11:0] AAEXE_OFS_CMD = 12'h008;
    localparam logic [11:0] AAEXE_OFS_STATUS = 12'h00c;
    // File register window: byte address = base + 4 * index
    localparam logic [2:0] AAEXE_FILE_BASE_TOP = 3'h1;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int AAEXE_CMD_OP_LSB = 0;
    localparam int AAEXE_CMD_DEST_BIT = 3;
    localparam int AAEXE_CMD_BIT_LSB = 4;
    localparam int AAEXE_CMD_ADDR_LSB = 8;
    localparam int AAEXE_CMD_LIT_LSB = 16;
    localparam int AAEXE_FLAG_CARRY_BIT = 0;
    localparam int AAEXE_FLAG_NIBBLE_BIT = 1;
    localparam int AAEXE_FLAG_ZERO_BIT = 2;
    localparam int AAEXE_STAT_BUSY_BIT = 0;
    localparam int AAEXE_STAT_SKIP_BIT = 1;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [7:0] AAEXE_ACC_RST = 8'h00;
    localparam logic [7:0] AAEXE_LATCH_RST = 8'h00;
    // Address of the file register that maps the I/O port
    localparam logic [6:0] AAEXE_IO_ADDR_DEF = 7'h06;

    // =====================================================================
    // Operation codes
    // =====================================================================
    localparam logic [2:0] AAEXE_OP_ADD_IMM = 3'h0;
    localparam logic [2:0] AAEXE_OP_ADD_REG = 3'h1;
    localparam logic [2:0] AAEXE_OP_CLR_BIT = 3'h2;
    localparam logic [2:0] AAEXE_OP_SET_BIT = 3'h3;
    localparam logic [2:0] AAEXE_OP_AND_IMM = 3'h4;
    localparam logic [2:0] AAEXE_OP_AND_REG = 3'h5;
    localparam logic [2:0] AAEXE_OP_SKIP_ONE = 3'h6;
    localparam logic [2:0] AAEXE_OP_SKIP_ZERO = 3'h7;

    // =====================================================================
    // Types
    // =====================================================================
    typedef enum logic [1:0] {AAEXE_IDLE, AAEXE_EXEC, AAEXE_NOP} aaexe_st_t;

    typedef struct packed {
        logic zero;
        logic nibble_carry_flag;
        logic carry;
    } aaexe_flags_t;

    typedef struct packed {
        logic [7:0] lit;
        logic [6:0] addr;
        logic [2:0] bit_idx;
        logic dest;
        logic [2:0] op;
    } aaexe_cmd_t;

    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] wdata;
    } aaexe_mem_req_t;

endpackage : aaexe_pkg

// [hw/aaexe_mem.sv]
/*
 * File register memory: one port, synchronous write, registered read.
 * Assumes the owner issues at most one access per cycle.
 */
module aaexe_mem
    import aaexe_pkg::*;
#(
    parameter int DEPTH = AAEXE_DEPTH
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire aaexe_mem_req_t req,
    output logic [7:0] rdata
);

    // =====================================================================
    // Storage
    // =====================================================================
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rdata_q;

    // Write port
    always_ff @(posedge pclk)
    begin
        if (req.we)
        begin
            mem_q[req.addr] <= req.wdata;
        end
    end

    // Registered read, valid one cycle after the address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            rdata_q <= mem_q[req.addr];
        end
    end

    assign rdata = rdata_q;

endmodule : aaexe_mem

// [hw/aaexe_core.sv]
/*
 * Execute unit for add, AND, bit clear/set and bit test-and-skip on an
 * 8-bit accumulator and a 128-entry file register space, driven over APB.
 * Assumes a synchronous APB master on pclk; io_pins_in is asynchronous.
 */
// Implementation choices: the register addresses and the APB interface to the registers.
module aaexe_core
    import aaexe_pkg::*;
#(
    parameter logic [6:0] IO_ADDR = AAEXE_IO_ADDR_DEF
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] io_pins_in,
    output logic [7:0] io_latch_out,
    output logic busy,
    output logic skip_pending
);

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        aaexe_st_t st;
        logic [1:0] rdcnt;
        logic [7:0] acc;
        aaexe_flags_t flags;
        aaexe_cmd_t cmd;
        logic skip;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [7:0] latch;
        logic [31:0] prdata;
    } aaexe_state_t;

    aaexe_state_t s_q;
    aaexe_state_t s_d;
    aaexe_mem_req_t mem_req;
    logic [7:0] mem_rdata;

    // Address decode terms
    logic access;
    logic is_acc;
    logic is_flags;
    logic is_cmd;
    logic is_status;
    logic is_file;
    logic [6:0] file_idx;

    // Datapath terms
    logic [7:0] reg_val;
    logic [7:0] opnd;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [7:0] and_res;
    logic [7:0] bit_mask;
    logic tested;

    // =====================================================================
    // File register memory
    // =====================================================================
    aaexe_mem #(
        .DEPTH(AAEXE_DEPTH)
    ) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .req(mem_req),
        .rdata(mem_rdata)
    );

    // =====================================================================
    // Decode
    // =====================================================================
    // APB address decode, one aligned word per register
    always_comb
    begin
        access = psel && penable;
        is_acc = 1'b0;
        is_flags = 1'b0;
        is_cmd = 1'b0;
        is_status = 1'b0;
        is_file = 1'b0;
        file_idx = paddr[8:2];
        if (paddr == AAEXE_OFS_ACC)
        begin
            is_acc = 1'b1;
        end
        else if (paddr == AAEXE_OFS_FLAGS)
        begin
            is_flags = 1'b1;
        end
        else if (paddr == AAEXE_OFS_CMD)
        begin
            is_cmd = 1'b1;
        end
        else if (paddr == AAEXE_OFS_STATUS)
        begin
            is_status = 1'b1;
        end
        else if (paddr[11:9] == AAEXE_FILE_BASE_TOP && paddr[1:0] == 2'b00)
        begin
            is_file = 1'b1;
        end
    end

    // =====================================================================
    // Datapath
    // =====================================================================
    // Operand select and arithmetic for the held command
    always_comb
    begin
        // I/O register reads the pins, not the output latch
        if (s_q.cmd.addr == IO_ADDR)
        begin
            reg_val = s_q.pin_s2;
        end
        else
        begin
            reg_val = mem_rdata;
        end
        if (s_q.cmd.op == AAEXE_OP_ADD_IMM || s_q.cmd.op == AAEXE_OP_AND_IMM)
        begin
            opnd = s_q.cmd.lit;
        end
        else
        begin
            opnd = reg_val;
        end
        sum9 = {1'b0, s_q.acc} + {1'b0, opnd};
        nib5 = {1'b0, s_q.acc[3:0]} + {1'b0, opnd[3:0]};
        and_res = s_q.acc & opnd;
        bit_mask = 8'h01 << s_q.cmd.bit_idx;
        tested = |(reg_val & bit_mask);
    end

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb
    begin
        s_d = s_q;
        mem_req = '0;
        pready = 1'b0;
        pslverr = 1'b0;
        // Two-stage pin synchroniser
        s_d.pin_s1 = io_pins_in;
        s_d.pin_s2 = s_q.pin_s1;
        case (s_q.st)
            AAEXE_IDLE:
            begin
                if (access && !pwrite)
                begin
                    // Reads: address, capture, answer
                    if (s_q.rdcnt == 2'd0)
                    begin
                        s_d.rdcnt = 2'd1;
                        mem_req.addr = file_idx;
                    end
                    else if (s_q.rdcnt == 2'd1)
                    begin
                        s_d.rdcnt = 2'd2;
                        s_d.prdata = 32'h0000_0000;
                        if (is_acc)
                        begin
                            s_d.prdata[7:0] = s_q.acc;
                        end
                        else if (is_flags)
                        begin
                            s_d.prdata[AAEXE_FLAG_CARRY_BIT] = s_q.flags.carry;
                            s_d.prdata[AAEXE_FLAG_NIBBLE_BIT] =
                                s_q.flags.nibble_carry_flag;
                            s_d.prdata[AAEXE_FLAG_ZERO_BIT] = s_q.flags.zero;
                        end
                        else if (is_cmd)
                        begin
                            s_d.prdata[23:0] = {s_q.cmd.lit, 1'b0,
                                s_q.cmd.addr, 1'b0, s_q.cmd.bit_idx,
                                s_q.cmd.dest, s_q.cmd.op};
                        end
                        else if (is_status)
                        begin
                            s_d.prdata[AAEXE_STAT_SKIP_BIT] = s_q.skip;
                        end
                        else if (is_file && file_idx == IO_ADDR)
                        begin
                            s_d.prdata[7:0] = s_q.pin_s2;
                        end
                        else if (is_file)
                        begin
                            s_d.prdata[7:0] = mem_rdata;
                        end
                    end
                    else
                    begin
                        pready = 1'b1;
                        pslverr = !(is_acc || is_flags || is_cmd ||
                            is_status || is_file);
                        s_d.rdcnt = 2'd0;
                    end
                end
                else if (access && pwrite)
                begin
                    // Writes complete in the first access cycle
                    pready = 1'b1;
                    pslverr = !(is_acc || is_flags || is_cmd || is_file);
                    if (is_acc)
                    begin
                        s_d.acc = pwdata[7:0];
                    end
                    else if (is_flags)
                    begin
                        s_d.flags.carry = pwdata[AAEXE_FLAG_CARRY_BIT];
                        s_d.flags.nibble_carry_flag =
                            pwdata[AAEXE_FLAG_NIBBLE_BIT];
                        s_d.flags.zero = pwdata[AAEXE_FLAG_ZERO_BIT];
                    end
                    else if (is_cmd && s_q.skip)
                    begin
                        // Discarded command runs as a no_operation cycle
                        s_d.skip = 1'b0;
                        s_d.st = AAEXE_NOP;
                    end
                    else if (is_cmd)
                    begin
                        s_d.cmd.op = pwdata[AAEXE_CMD_OP_LSB +: AAEXE_OPW];
                        s_d.cmd.dest = pwdata[AAEXE_CMD_DEST_BIT];
                        s_d.cmd.bit_idx = pwdata[AAEXE_CMD_BIT_LSB +: AAEXE_BW];
                        s_d.cmd.addr = pwdata[AAEXE_CMD_ADDR_LSB +: AAEXE_AW];
                        s_d.cmd.lit = pwdata[AAEXE_CMD_LIT_LSB +: AAEXE_DW];
                        mem_req.addr = pwdata[AAEXE_CMD_ADDR_LSB +: AAEXE_AW];
                        s_d.st = AAEXE_EXEC;
                    end
                    else if (is_file)
                    begin
                        mem_req.we = 1'b1;
                        mem_req.addr = file_idx;
                        mem_req.wdata = pwdata[7:0];
                        if (file_idx == IO_ADDR)
                        begin
                            s_d.latch = pwdata[7:0];
                        end
                    end
                end
            end
            AAEXE_EXEC:
            begin
                s_d.st = AAEXE_IDLE;
                mem_req.addr = s_q.cmd.addr;
                mem_req.wdata = 8'h00;
                case (s_q.cmd.op)
                    AAEXE_OP_ADD_IMM, AAEXE_OP_ADD_REG:
                    begin
                        // Flags from the 9-bit and 5-bit sums
                        s_d.flags.carry = sum9[8];
                        s_d.flags.nibble_carry_flag = nib5[4];
                        s_d.flags.zero = (sum9[7:0] == 8'h00);
                        if (s_q.cmd.op == AAEXE_OP_ADD_REG && s_q.cmd.dest)
                        begin
                            mem_req.we = 1'b1;
                            mem_req.wdata = sum9[7:0];
                        end
                        else
                        begin
                            s_d.acc = sum9[7:0];
                        end
                    end
                    AAEXE_OP_AND_IMM, AAEXE_OP_AND_REG:
                    begin
                        s_d.flags.zero = (and_res == 8'h00);
                        if (s_q.cmd.op == AAEXE_OP_AND_REG && s_q.cmd.dest)
                        begin
                            mem_req.we = 1'b1;
                            mem_req.wdata = and_res;
                        end
                        else
                        begin
                            s_d.acc = and_res;
                        end
                    end
                    AAEXE_OP_CLR_BIT:
                    begin
                        mem_req.we = 1'b1;
                        mem_req.wdata = reg_val & ~bit_mask;
                    end
                    AAEXE_OP_SET_BIT:
                    begin
                        mem_req.we = 1'b1;
                        mem_req.wdata = reg_val | bit_mask;
                    end
                    AAEXE_OP_SKIP_ONE:
                    begin
                        s_d.skip = tested;
                    end
                    default:
                    begin
                        s_d.skip = !tested;
                    end
                endcase
                if (mem_req.we && s_q.cmd.addr == IO_ADDR)
                begin
                    s_d.latch = mem_req.wdata;
                end
            end
            AAEXE_NOP:
            begin
                s_d.st = AAEXE_IDLE;
            end
            default:
            begin
                s_d.st = AAEXE_IDLE;
            end
        endcase
    end

    // =====================================================================
    // State register
    // =====================================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign prdata = s_q.prdata;
    assign io_latch_out = s_q.latch;
    assign busy = (s_q.st != AAEXE_IDLE);
    assign skip_pending = s_q.skip;

endmodule : aaexe_core

// [verification/aaexe_core_properties.sv]
/*
 * Port-level properties of the execute unit aaexe_core.
 * Assumes one pclk domain and an active-low asynchronous presetn.
 */
module aaexe_core_properties
    import aaexe_pkg::*;
#(
    parameter logic [6:0] IO_ADDR = AAEXE_IO_ADDR_DEF
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] io_pins_in,
    input wire logic [7:0] io_latch_out,
    input wire logic busy,
    input wire logic skip_pending
);
    // ==========
    // Helpers
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Accepted command write and byte address of the I/O file register
    logic cmd_wr;
    logic [11:0] io_ofs;
    assign cmd_wr = psel && penable && pready && pwrite
        && paddr == AAEXE_OFS_CMD;
    assign io_ofs = 12'h200 + {3'h0, IO_ADDR, 2'b00};

    // ==========
    // Properties
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    exec_two_cycles_a: assert property (
        cmd_wr |=> busy ##1 !busy)
        else $error("command not one extra cycle");
    busy_stall_a: assert property (busy |-> !pready)
        else $error("answer given while busy");
    skip_clear_a: assert property (
        cmd_wr && skip_pending |=> !skip_pending)
        else $error("skip not consumed by command");
    skip_hold_a: assert property (
        skip_pending && !cmd_wr |=> skip_pending)
        else $error("skip lost without command");
    status_read_a: assert property (
        pready && !pwrite && paddr == AAEXE_OFS_STATUS
        |-> prdata == {30'h0, skip_pending, 1'b0})
        else $error("status read wrong");
    latch_cause_a: assert property (
        !$stable(io_latch_out) |-> $past(busy)
        || $past(psel && penable && pready && pwrite && paddr == io_ofs))
        else $error("latch changed without cause");
    read_wait_a: assert property (
        psel && penable && !pwrite && !busy && !$past(penable)
        |-> !pready ##1 !pready ##1 pready)
        else $error("read not in third access cycle");
    write_nowait_a: assert property (
        psel && penable && pwrite && !busy && !$past(penable) |-> pready)
        else $error("write not answered at once");
    unmapped_err_a: assert property (
        pready && paddr[11:9] == 3'h0 && paddr[8:4] != 5'h00 |-> pslverr)
        else $error("unmapped access not refused");
    status_wr_err_a: assert property (
        pready && pwrite && paddr == AAEXE_OFS_STATUS |-> pslverr)
        else $error("status write not refused");
endmodule : aaexe_core_properties

bind aaexe_core aaexe_core_properties #(.IO_ADDR(IO_ADDR)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_pins_in(io_pins_in),
    .io_latch_out(io_latch_out), .busy(busy), .skip_pending(skip_pending)
);

// [verification/add_and_bit_ops_execute_tb.sv]
/*
 * Self-checking bench for aaexe_core over APB.
 * Assumes the file register map and command layout of aaexe_pkg.
 */
module add_and_bit_ops_execute_tb;
    import aaexe_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========
    // Signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] io_pins_in = 8'h0f;
    logic [7:0] io_latch_out;
    logic busy;
    logic skip_pending;
    int bad_count = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic er;
    logic [7:0] e;
    logic [7:0] m;
    logic [2:0] sop [4] = '{AAEXE_OP_SKIP_ONE, AAEXE_OP_SKIP_ONE,
        AAEXE_OP_SKIP_ZERO, AAEXE_OP_SKIP_ZERO};
    logic [2:0] sbt [4] = '{3'h2, 3'h3, 3'h3, 3'h2};
    logic skp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    aaexe_core DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .io_pins_in(io_pins_in),
        .io_latch_out(io_latch_out), .busy(busy),
        .skip_pending(skip_pending)
    );

    // ==========
    // Tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // One APB transfer, waits for pready; only the watchdog ends a hang
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rchk

    function logic [11:0] fa(input logic [6:0] i);
        return 12'h200 + {3'h0, i, 2'b00};
    endfunction : fa

    task cmd(input logic [2:0] op, input logic dest, input logic [2:0] b,
        input logic [6:0] f, input logic [7:0] k);
        apb(1'b1, AAEXE_OFS_CMD, {8'h00, k, 1'b0, f, 1'b0, b, dest, op});
    endtask : cmd

    // Add with flag expectations worked out here
    task add_case(input logic [2:0] op, input logic dest,
        input logic [7:0] a, input logic [7:0] v, input logic [6:0] f);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, a} + {1'b0, v};
        n = {1'b0, a[3:0]} + {1'b0, v[3:0]};
        apb(1'b1, AAEXE_OFS_ACC, {24'h0, a});
        if (op == AAEXE_OP_ADD_REG)
            apb(1'b1, fa(f), {24'h0, v});
        cmd(op, dest, 3'h0, f, v);
        rchk(AAEXE_OFS_ACC, {24'h0, dest ? a : s[7:0]});
        rchk(AAEXE_OFS_FLAGS, {29'h0, s[7:0] == 8'h0, n[4], s[8]});
        if (dest)
            rchk(fa(f), {24'h0, s[7:0]});
    endtask : add_case

    // ==========
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        $display("unexpected at %0t: watchdog", $time);
        conclude;
    end

    // ==========
    // Tests
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rchk(AAEXE_OFS_ACC, 32'h0);
        rchk(AAEXE_OFS_FLAGS, 32'h0);
        rchk(AAEXE_OFS_STATUS, 32'h0);
        // Adds: nibble carry, wrap to zero, literal 255, register forms
        add_case(AAEXE_OP_ADD_IMM, 1'b0, 8'h0f, 8'h01, 7'h00);
        add_case(AAEXE_OP_ADD_IMM, 1'b0, 8'h01, 8'hff, 7'h00);
        rchk(AAEXE_OFS_CMD, 32'h00ff_0000);
        add_case(AAEXE_OP_ADD_IMM, 1'b0, 8'h80, 8'h80, 7'h00);
        add_case(AAEXE_OP_ADD_REG, 1'b0, 8'h9c, 8'h74, 7'h7f);
        add_case(AAEXE_OP_ADD_REG, 1'b1, 8'hff, 8'h01, 7'h00);
        // AND keeps carry and nibble carry
        apb(1'b1, AAEXE_OFS_ACC, 32'hf0);
        apb(1'b1, AAEXE_OFS_FLAGS, 32'h3);
        cmd(AAEXE_OP_AND_IMM, 1'b0, 3'h0, 7'h00, 8'h0f);
        rchk(AAEXE_OFS_ACC, 32'h0);
        rchk(AAEXE_OFS_FLAGS, 32'h7);
        apb(1'b1, AAEXE_OFS_ACC, 32'h2d);
        apb(1'b1, fa(7'h03), 32'h3c);
        cmd(AAEXE_OP_AND_REG, 1'b1, 3'h0, 7'h03, 8'h00);
        rchk(fa(7'h03), 32'h2c);
        rchk(AAEXE_OFS_ACC, 32'h2d);
        rchk(AAEXE_OFS_FLAGS, 32'h3);
        cmd(AAEXE_OP_AND_REG, 1'b0, 3'h0, 7'h03, 8'h00);
        rchk(AAEXE_OFS_ACC, 32'h2c);
        // Clear and set every bit index
        apb(1'b1, AAEXE_OFS_FLAGS, 32'h5);
        for (int b = 0; b < 8; b++)
        begin
            m = 8'h01 << b;
            apb(1'b1, fa(7'h09), 32'ha5);
            cmd(AAEXE_OP_CLR_BIT, 1'b0, b[2:0], 7'h09, 8'h00);
            rchk(fa(7'h09), {24'h0, 8'ha5 & ~m});
            cmd(AAEXE_OP_SET_BIT, 1'b0, b[2:0], 7'h09, 8'h00);
            rchk(fa(7'h09), {24'h0, 8'ha5 | m});
        end
        rchk(AAEXE_OFS_FLAGS, 32'h5);
        // Test-and-skip, both variants, both outcomes
        apb(1'b1, fa(7'h05), 32'h04);
        apb(1'b1, AAEXE_OFS_ACC, 32'h10);
        e = 8'h10;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, AAEXE_OFS_FLAGS, 32'h5);
            cmd(sop[i], 1'b0, sbt[i], 7'h05, 8'h00);
            rchk(AAEXE_OFS_STATUS, {30'h0, skp[i], 1'b0});
            rchk(AAEXE_OFS_FLAGS, 32'h5);
            cmd(AAEXE_OP_ADD_IMM, 1'b0, 3'h0, 7'h00, 8'h01);
            if (!skp[i])
                e = e + 8'h01;
            rchk(AAEXE_OFS_ACC, {24'h0, e});
            rchk(AAEXE_OFS_STATUS, 32'h0);
        end
        // I/O register reads the pins, writes the latch
        io_pins_in <= 8'h3c;
        apb(1'b1, fa(AAEXE_IO_ADDR_DEF), 32'hf0);
        @(negedge pclk);
        check({24'h0, io_latch_out}, 32'hf0);
        rchk(fa(AAEXE_IO_ADDR_DEF), 32'h3c);
        cmd(AAEXE_OP_SET_BIT, 1'b0, 3'h7, AAEXE_IO_ADDR_DEF, 8'h00);
        rchk(fa(AAEXE_IO_ADDR_DEF), 32'h3c);
        check({24'h0, io_latch_out}, 32'hbc);
        // Refused accesses
        apb(1'b0, 12'h010, 32'h0);
        check({31'h0, er}, 32'h1);
        apb(1'b1, AAEXE_OFS_STATUS, 32'h2);
        check({31'h0, er}, 32'h1);
        conclude;
    end
endmodule : add_and_bit_ops_execute_tb
